// ---- src/param_lock_consts.vh ----
// Purpose: constants for the acquisition parameter lock register bank
// Assumes: 32-bit axi4-lite register bus, byte addresses
// Notes: offsets are byte addresses of aligned words
`ifndef PARAM_LOCK_CONSTS_VH
`define PARAM_LOCK_CONSTS_VH

`define ADDR_W 8
// register offsets
`define OFF_TRANSPORT_LOCK 8'h00
`define OFF_GROUP_SELECT 8'h04
`define OFF_GROUP_STATE 8'h08
`define OFF_FRAME_DIM 8'h0c
`define OFF_PIXEL_ENC 8'h10
`define OFF_EXT_PAYLOAD 8'h14
`define OFF_STREAM_CFG 8'h18
`define OFF_COMMAND 8'h1c
`define OFF_STATUS 8'h20
`define OFF_INTERNAL 8'h24
// lock group codes
`define GRP_FRAME_DIM 2'h0
`define GRP_PIXEL_ENC 2'h1
`define GRP_PIXEL_WIDTH 2'h2
`define GRP_EXT_PAYLOAD 2'h3
// command bits
`define CMD_CAPTURE_BIT 0
`define CMD_TRANSFER_BIT 1
`define CMD_CAPTURE_STOP_BIT 2
`define CMD_TRANSFER_STOP_BIT 3
// pixel encoding field: width code lives in the top byte
`define PIX_WIDTH_MSB 31
`define PIX_WIDTH_LSB 24
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
// reset values
`define RST_GROUP_STATE 4'hf
`define RST_WORD 32'h0000_0000

`endif

// ---- src/acquisition_parameter_lock.v ----
// Purpose: transport lock register bank that freezes stream settings during capture
// Assumes: one clock, synchronous active-low reset, axi4-lite slave with one access of each kind
// Notes: a refused write keeps the stored value and answers slverr
//
// Local design decisions: register access over AXI4-Lite and the address map.
`include "param_lock_consts.vh"

module acquisition_parameter_lock #(
  parameter DATA_W = 32
) (
  input wire clk_sys_i,
  input wire rst_b_i,
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [DATA_W-1:0] s_axi_wdata,
  input wire [DATA_W/8-1:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [DATA_W-1:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire int_update_i,
  input wire [DATA_W-1:0] int_frame_dim_i,
  input wire [DATA_W-1:0] int_pixel_enc_i,
  output reg [DATA_W-1:0] frame_dim_o,
  output reg [DATA_W-1:0] pixel_enc_o,
  output reg ext_payload_o,
  output reg [DATA_W-1:0] stream_cfg_o,
  output reg capture_active_o,
  output reg transfer_active_o,
  output reg transport_lock_o
);

  // group state bits indexed by group code
  reg [3:0] lock_group_state_ff;
  reg [1:0] lock_group_select_ff;
  reg [`ADDR_W-1:0] aw_addr_ff;
  reg [DATA_W-1:0] w_data_ff;
  reg [DATA_W/8-1:0] w_strb_ff;
  reg aw_held_ff;
  reg w_held_ff;
  reg [3:0] refused_cnt_ff;

  wire [DATA_W-1:0] stat_word;

  // byte-lane merge of a write into a stored word
  function [DATA_W-1:0] merge;
    input [DATA_W-1:0] old_v;
    input [DATA_W-1:0] new_v;
    input [DATA_W/8-1:0] strb;
    integer b;
    begin
      merge = old_v;
      for (b = 0; b < DATA_W/8; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
    end
  endfunction

  // a group is frozen when lock is set and its state is true
  function frozen;
    input lock_v;
    input [3:0] states;
    input [1:0] grp;
    begin
      frozen = lock_v & states[grp];
    end
  endfunction

  // write path state; decode sees the held copies at commit
  wire [`ADDR_W-1:0] wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  wire [DATA_W-1:0] wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
  wire [DATA_W/8-1:0] wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
  // commit once both channels are held and no answer is pending
  wire wr_go = aw_held_ff & w_held_ff & ~s_axi_bvalid;
  wire running = capture_active_o | transfer_active_o;

  // freeze decisions per group; binning-like frame settings follow
  wire frz_frame = frozen(transport_lock_o, lock_group_state_ff, `GRP_FRAME_DIM);
  wire frz_enc = frozen(transport_lock_o, lock_group_state_ff, `GRP_PIXEL_ENC);
  wire frz_width = frozen(transport_lock_o, lock_group_state_ff, `GRP_PIXEL_WIDTH);
  wire frz_ext = frozen(transport_lock_o, lock_group_state_ff, `GRP_EXT_PAYLOAD);

  wire [DATA_W-1:0] enc_new = merge(pixel_enc_o, wr_data, wr_strb);
  wire width_same = enc_new[`PIX_WIDTH_MSB:`PIX_WIDTH_LSB] == pixel_enc_o[`PIX_WIDTH_MSB:`PIX_WIDTH_LSB];
  wire enc_denied = frz_enc | (frz_width & ~width_same);

  // per-address refusal decision for the pending write
  // unmapped addresses answer slverr but are not counted as refusals
  reg wr_denied;
  reg wr_mapped;
  always @* begin
    wr_denied = 1'b0;
    wr_mapped = 1'b1;
    if (wr_addr == `OFF_TRANSPORT_LOCK) begin
      wr_denied = running & ~wr_data[0] & wr_strb[0];
    end else if (wr_addr == `OFF_GROUP_SELECT) begin
      wr_denied = 1'b0;
    end else if (wr_addr == `OFF_GROUP_STATE) begin
      wr_denied = transport_lock_o;
    end else if (wr_addr == `OFF_FRAME_DIM) begin
      wr_denied = frz_frame;
    end else if (wr_addr == `OFF_PIXEL_ENC) begin
      wr_denied = enc_denied;
    end else if (wr_addr == `OFF_EXT_PAYLOAD) begin
      wr_denied = frz_ext;
    end else if (wr_addr == `OFF_STREAM_CFG) begin
      wr_denied = transport_lock_o;
    end else if (wr_addr == `OFF_COMMAND) begin
      wr_denied = ~transport_lock_o & wr_strb[0] &
                  (wr_data[`CMD_CAPTURE_BIT] | wr_data[`CMD_TRANSFER_BIT]);
    end else begin
      wr_mapped = 1'b0;
    end
  end

  // write channel handshakes and register updates
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= {`ADDR_W{1'b0}};
      w_data_ff <= `RST_WORD;
      w_strb_ff <= {(DATA_W/8){1'b0}};
      transport_lock_o <= 1'b0;
      lock_group_select_ff <= `GRP_FRAME_DIM;
      // all four groups (size, encoding, width, ext payload) locked by default
      lock_group_state_ff <= `RST_GROUP_STATE;
      frame_dim_o <= `RST_WORD;
      pixel_enc_o <= `RST_WORD;
      ext_payload_o <= 1'b0;
      stream_cfg_o <= `RST_WORD;
      capture_active_o <= 1'b0;
      transfer_active_o <= 1'b0;
      refused_cnt_ff <= 4'h0;
    end else begin
      // accept each channel once, hold it until both present
      // ready must not wait for the other channel, or a paired offer would stall
      s_axi_awready <= ~aw_held_ff & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
      s_axi_wready <= ~w_held_ff & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // internal updates only to unfrozen groups
      // a bus write committing in the same cycle wins over this update
      if (int_update_i) begin
        if (!frz_frame) begin
          frame_dim_o <= int_frame_dim_i;
        end
        if (!frz_enc && !(frz_width && int_pixel_enc_i[`PIX_WIDTH_MSB:`PIX_WIDTH_LSB] !=
            pixel_enc_o[`PIX_WIDTH_MSB:`PIX_WIDTH_LSB])) begin
          pixel_enc_o <= int_pixel_enc_i;
        end
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_denied | ~wr_mapped) ? `RESP_SLVERR : `RESP_OKAY;
        // saturating count of refused writes for status
        if (wr_denied && refused_cnt_ff != 4'hf) begin
          refused_cnt_ff <= refused_cnt_ff + 4'h1;
        end
        if (!wr_denied && wr_mapped) begin
          if (wr_addr == `OFF_TRANSPORT_LOCK) begin
            // lock bit 0 holds 0 or 1
            if (wr_strb[0]) begin
              transport_lock_o <= wr_data[0];
            end
          end else if (wr_addr == `OFF_GROUP_SELECT) begin
            if (wr_strb[0]) begin
              lock_group_select_ff <= wr_data[1:0];
            end
          end else if (wr_addr == `OFF_GROUP_STATE) begin
            if (wr_strb[0]) begin
              lock_group_state_ff[lock_group_select_ff] <= wr_data[0];
            end
          end else if (wr_addr == `OFF_FRAME_DIM) begin
            frame_dim_o <= merge(frame_dim_o, wr_data, wr_strb);
          end else if (wr_addr == `OFF_PIXEL_ENC) begin
            pixel_enc_o <= enc_new;
          end else if (wr_addr == `OFF_EXT_PAYLOAD) begin
            if (wr_strb[0]) begin
              ext_payload_o <= wr_data[0];
            end
          end else if (wr_addr == `OFF_STREAM_CFG) begin
            stream_cfg_o <= merge(stream_cfg_o, wr_data, wr_strb);
          end else if (wr_addr == `OFF_COMMAND) begin
            if (wr_strb[0]) begin
              // start bits set, stop bits clear; start wins when both
              if (wr_data[`CMD_CAPTURE_BIT]) begin
                capture_active_o <= 1'b1;
              end else if (wr_data[`CMD_CAPTURE_STOP_BIT]) begin
                capture_active_o <= 1'b0;
              end
              if (wr_data[`CMD_TRANSFER_BIT]) begin
                transfer_active_o <= 1'b1;
              end else if (wr_data[`CMD_TRANSFER_STOP_BIT]) begin
                transfer_active_o <= 1'b0;
              end
            end
          end
        end
      end
    end
  end

  // status word: activity, lock and refusal count
  assign stat_word = {{(DATA_W-7){1'b0}}, refused_cnt_ff, transport_lock_o,
                      transfer_active_o, capture_active_o};

  // read channel with address decode
  // one read at a time; arready waits until the last answer is taken
  always @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RST_WORD;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        if (s_axi_araddr == `OFF_TRANSPORT_LOCK) begin
          s_axi_rdata <= {{(DATA_W-1){1'b0}}, transport_lock_o};
        end else if (s_axi_araddr == `OFF_GROUP_SELECT) begin
          s_axi_rdata <= {{(DATA_W-2){1'b0}}, lock_group_select_ff};
        end else if (s_axi_araddr == `OFF_GROUP_STATE) begin
          s_axi_rdata <= {{(DATA_W-1){1'b0}}, lock_group_state_ff[lock_group_select_ff]};
        end else if (s_axi_araddr == `OFF_FRAME_DIM) begin
          s_axi_rdata <= frame_dim_o;
        end else if (s_axi_araddr == `OFF_PIXEL_ENC) begin
          s_axi_rdata <= pixel_enc_o;
        end else if (s_axi_araddr == `OFF_EXT_PAYLOAD) begin
          s_axi_rdata <= {{(DATA_W-1){1'b0}}, ext_payload_o};
        end else if (s_axi_araddr == `OFF_STREAM_CFG) begin
          s_axi_rdata <= stream_cfg_o;
        end else if (s_axi_araddr == `OFF_COMMAND) begin
          s_axi_rdata <= `RST_WORD;
        end else if (s_axi_araddr == `OFF_STATUS) begin
          s_axi_rdata <= stat_word;
        end else begin
          s_axi_rdata <= `RST_WORD;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end
    end
  end

endmodule // acquisition_parameter_lock

// ---- testbench/param_lock_sva.sv ----
// Purpose: port-level checks of the parameter lock register bank
// Assumes: one clock, synchronous active-low reset
// Notes: group states are internal, so only ungrouped freezing is checked here
module param_lock_sva (
  input logic clk_sys_i,
  input logic rst_b_i,
  input logic s_axi_awvalid,
  input logic s_axi_wvalid,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic [1:0] s_axi_rresp,
  input logic [31:0] s_axi_rdata,
  input logic [31:0] stream_cfg_o,
  input logic capture_active_o,
  input logic transfer_active_o,
  input logic transport_lock_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // bus steps
  sequence s_wr_offer; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
  sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  // bus answers and holds
  a_wr_answer: assert property (s_wr_offer |-> ##[1:4] s_axi_bvalid)
    else $error("write answer missing");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_refused_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  // lock relations
  a_boot_unlocked: assert property ($rose(rst_b_i) |-> !transport_lock_o)
    else $error("lock set after reset");
  a_run_locked: assert property (capture_active_o || transfer_active_o |-> transport_lock_o)
    else $error("running without lock");
  a_start_locked: assert property ($rose(capture_active_o) || $rose(transfer_active_o) |-> $past(transport_lock_o))
    else $error("start while unlocked");
  a_stream_frozen: assert property ($changed(stream_cfg_o) |-> !$past(transport_lock_o))
    else $error("stream config changed while locked");
endmodule // param_lock_sva

bind acquisition_parameter_lock param_lock_sva param_lock_sva_inst (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .stream_cfg_o(stream_cfg_o),
  .capture_active_o(capture_active_o), .transfer_active_o(transfer_active_o), .transport_lock_o(transport_lock_o)
);

// ---- testbench/seq_source_model.sv ----
// Purpose: internal sequencer source pushing frame and encoding updates
// Assumes: the bench calls push between bus transfers
// Notes: data lines show the inverse value after an update, zero before the first
module seq_source_model (
  input wire logic clk_sys_i,
  output logic upd_o,
  output logic [31:0] frame_o,
  output logic [31:0] enc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle at time zero
  initial begin
    upd_o = 1'h0;
    frame_o = 32'h0;
    enc_o = 32'h0;
  end
  // one-cycle update request
  task automatic push(input logic [31:0] f, input logic [31:0] e);
    @(posedge clk_sys_i);
    upd_o <= 1'h1;
    frame_o <= f;
    enc_o <= e;
    @(posedge clk_sys_i);
    upd_o <= 1'h0;
    frame_o <= ~f;
    enc_o <= ~e;
  endtask
endmodule // seq_source_model

// ---- testbench/tb_acquisition_parameter_lock.sv ----
// Purpose: self-checking bench for the parameter lock register bank
// Assumes: axi4-lite master tasks, 20 MHz clock
// Notes: response is accepted one cycle late to exercise the hold
`include "param_lock_consts.vh"
module tb_acquisition_parameter_lock;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'h0, rst_b_i = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, int_update_i, ext_payload_o;
  logic capture_active_o, transfer_active_o, transport_lock_o;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, int_frame_dim_i, int_pixel_enc_i, frame_dim_o, pixel_enc_o, stream_cfg_o;
  int n_errors = 0, tests_run = 0;
  acquisition_parameter_lock acquisition_parameter_lock_inst (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .int_update_i(int_update_i), .int_frame_dim_i(int_frame_dim_i), .int_pixel_enc_i(int_pixel_enc_i),
    .frame_dim_o(frame_dim_o), .pixel_enc_o(pixel_enc_o), .ext_payload_o(ext_payload_o),
    .stream_cfg_o(stream_cfg_o), .capture_active_o(capture_active_o), .transfer_active_o(transfer_active_o),
    .transport_lock_o(transport_lock_o));
  seq_source_model seq_source_model_inst (.clk_sys_i(clk_sys_i), .upd_o(int_update_i),
    .frame_o(int_frame_dim_i), .enc_o(int_pixel_enc_i));
  // 50 ns clock
  always #25 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // write: address and data together, response taken one cycle after it shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    forever begin
      @(posedge clk_sys_i);
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid) s_axi_bready <= 1'h1;
    end
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    forever begin
      @(posedge clk_sys_i);
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid) s_axi_rready <= 1'h1;
    end
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    #(4000 * 50);
    n_errors++;
    test_done();
  end
  // main sequence
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_b_i <= 1'h1;
    rd(`OFF_TRANSPORT_LOCK, 32'h0, `RESP_OKAY);
    for (int g = 0; g < 4; g++) begin
      wr(`OFF_GROUP_SELECT, 32'(g), `RESP_OKAY);
      rd(`OFF_GROUP_STATE, 32'h1, `RESP_OKAY);
    end
    wr(`OFF_COMMAND, 32'h1, `RESP_SLVERR);
    wr(`OFF_COMMAND, 32'h2, `RESP_SLVERR);
    chk({30'h0, capture_active_o, transfer_active_o}, 32'h0);
    wr(`OFF_STREAM_CFG, 32'h0000_1234, `RESP_OKAY);
    wr(`OFF_FRAME_DIM, 32'h0280_01e0, `RESP_OKAY);
    wr(`OFF_GROUP_SELECT, 32'h1, `RESP_OKAY);
    rd(`OFF_GROUP_SELECT, 32'h1, `RESP_OKAY);
    wr(`OFF_GROUP_STATE, 32'h0, `RESP_OKAY);
    rd(`OFF_GROUP_STATE, 32'h0, `RESP_OKAY);
    wr(`OFF_TRANSPORT_LOCK, 32'h1, `RESP_OKAY);
    rd(`OFF_TRANSPORT_LOCK, 32'h1, `RESP_OKAY);
    wr(`OFF_STREAM_CFG, 32'h0000_5678, `RESP_SLVERR);
    chk(stream_cfg_o, 32'h0000_1234);
    wr(`OFF_FRAME_DIM, 32'h0100_0100, `RESP_SLVERR);
    chk(frame_dim_o, 32'h0280_01e0);
    wr(`OFF_GROUP_STATE, 32'h1, `RESP_SLVERR);
    wr(`OFF_PIXEL_ENC, 32'h0000_0055, `RESP_OKAY);
    wr(`OFF_PIXEL_ENC, 32'h0100_0055, `RESP_SLVERR);
    chk(pixel_enc_o, 32'h0000_0055);
    wr(`OFF_EXT_PAYLOAD, 32'h1, `RESP_SLVERR);
    chk({31'h0, ext_payload_o}, 32'h0);
    seq_source_model_inst.push(32'h0000_0dea, 32'h0100_0000);
    repeat (2) @(posedge clk_sys_i);
    chk(frame_dim_o, 32'h0280_01e0);
    chk(pixel_enc_o, 32'h0000_0055);
    wr(`OFF_COMMAND, 32'h1, `RESP_OKAY);
    wr(`OFF_COMMAND, 32'h2, `RESP_OKAY);
    chk({30'h0, capture_active_o, transfer_active_o}, 32'h3);
    rd(`OFF_STATUS, 32'h0000_003f, `RESP_OKAY);
    wr(`OFF_TRANSPORT_LOCK, 32'h0, `RESP_SLVERR);
    rd(`OFF_TRANSPORT_LOCK, 32'h1, `RESP_OKAY);
    wr(`OFF_COMMAND, 32'hc, `RESP_OKAY);
    wr(`OFF_TRANSPORT_LOCK, 32'h0, `RESP_OKAY);
    wr(`OFF_FRAME_DIM, 32'h0100_0100, `RESP_OKAY);
    rd(`OFF_FRAME_DIM, 32'h0100_0100, `RESP_OKAY);
    seq_source_model_inst.push(32'h0000_0777, 32'h0000_0055);
    repeat (2) @(posedge clk_sys_i);
    chk(frame_dim_o, 32'h0000_0777);
    wr(`OFF_EXT_PAYLOAD, 32'h1, `RESP_OKAY);
    chk({31'h0, ext_payload_o}, 32'h1);
    rd(`OFF_COMMAND, 32'h0, `RESP_OKAY);
    rd(8'h24, 32'h0, `RESP_SLVERR);
    wr(8'h24, 32'h1, `RESP_SLVERR);
    rd(`OFF_STATUS, 32'h0000_0040, `RESP_OKAY);
    test_done();
  end
endmodule // tb_acquisition_parameter_lock
